/* rtl/camb_defs.svh */
// Constants shared by the search memory block: offsets, fields, counts.
`ifndef CAMB_DEFS_SVH
`define CAMB_DEFS_SVH
// Storage geometry.
`define CAMB_WORDS 32
`define CAMB_BANK 16
// Register byte offsets.
`define CAMB_OFF_CTRL 8'h00
`define CAMB_OFF_WDATA 8'h04
`define CAMB_OFF_WDC 8'h08
`define CAMB_OFF_WCMD 8'h0c
`define CAMB_OFF_KEY 8'h10
`define CAMB_OFF_RES 8'h14
`define CAMB_OFF_VEC 8'h18
`define CAMB_OFF_ISTAT 8'h1c
`define CAMB_OFF_IMASK 8'h20
// Control and command field positions.
`define CAMB_CTRL_UNENC 2
`define CAMB_CTRL_INREG 3
`define CAMB_CTRL_OUTREG 4
`define CAMB_WCMD_MASK 8
// Interrupt event bit positions.
`define CAMB_INT_WR 0
`define CAMB_INT_SR 1
`define CAMB_INT_HIT 2
// Reset values and compare masks.
`define CAMB_CTRL_RST 5'h00
`define CAMB_INIT_BASE 32'h00000000
`define CAMB_ALL_ONES 32'hffffffff
`define CAMB_CARE31 32'h7fffffff
`endif

/* rtl/camb_pkg.sv */
// Types of the search memory block: modes, sequencer states, result word.
`default_nettype none
package camb_pkg;
   // Output modes; the fourth turns the block into a lookup table.
   typedef enum logic [1:0] {
      CAMB_SINGLE, CAMB_MULTI, CAMB_FAST, CAMB_LUT
   } camb_mode_t;
   // Word write sequencer.
   typedef enum logic [1:0] {W_IDLE, W_ADDR, W_DATA, W_MASK} camb_wst_t;
   // Search sequencer.
   typedef enum logic [1:0] {S_IDLE, S_INREG, S_CMP, S_CMP2} camb_sst_t;
   // One search result as it moves through the output stage.
   typedef struct packed {
      logic match;
      logic [4:0] idx;
      logic hi;
      logic done;
      logic [31:0] vec;
   } camb_res_t;
endpackage
`default_nettype wire

/* rtl/camb_array.sv */
// Storage array of the search memory with per-word parallel compare.
`default_nettype none
`include "camb_defs.svh"
module camb_array
   import camb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic dat_we_i,
   input wire logic dc_we_i,
   input wire logic [4:0] waddr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [31:0] wdc_i,
   input wire logic [31:0] key_i,
   input wire logic [31:0] kcare_i,
   input wire logic [4:0] raddr_i,
   output logic [31:0] rdata_o,
   output logic [31:0] hit_o
);
   // Stored words and their don't-care bits (1 means ignored).
   logic [31:0] dat_reg [`CAMB_WORDS];
   logic [31:0] dat_next [`CAMB_WORDS];
   logic [31:0] dc_reg [`CAMB_WORDS];
   logic [31:0] dc_next [`CAMB_WORDS];

   // Each entry updates itself and compares against the key.
   for (genvar g = 0; g < `CAMB_WORDS; g++) begin : g_ent
      // Next value of one entry.
      always_comb begin
         dat_next[g] = dat_reg[g];
         dc_next[g] = dc_reg[g];
         if (dat_we_i && waddr_i == 5'(g)) begin
            dat_next[g] = wdata_i;
         end
         if (dc_we_i && waddr_i == 5'(g)) begin
            dc_next[g] = wdc_i;
         end
      end
      // Reset loads the preset contents, later writes replace them.
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            dat_reg[g] <= `CAMB_INIT_BASE ^ 32'(g);
            dc_reg[g] <= 32'h0;
         end else begin
            dat_reg[g] <= dat_next[g];
            dc_reg[g] <= dc_next[g];
         end
      end
      // Masked bits can neither cause nor prevent a hit.
      assign hit_o[g] =
         ((dat_reg[g] ^ key_i) & ~dc_reg[g] & kcare_i) == 32'h0;
   end

   // Read port used for the lookup-table mode.
   assign rdata_o = dat_reg[raddr_i];

   // An all-masked word must hit whatever the key is.
   dc_ignore_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (dc_we_i && wdc_i == `CAMB_ALL_ONES) |=> hit_o[$past(waddr_i)])
      else $error("fully masked word does not hit");
endmodule
`default_nettype wire

/* rtl/camb_top.sv */
// Search memory block with APB registers, sequencers and interrupt.
//
// Register access over APB and the placing of the registers were left to the implementer.
`default_nettype none
`include "camb_defs.svh"
module camb_top
   import camb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic in_ce_i,
   input wire logic out_ce_i,
   input wire logic fab_wr_i,
   input wire logic fab_rd_i,
   input wire logic fab_sclr_i,
   output logic match_o,
   output logic [4:0] match_idx_o,
   output logic [15:0] match_vec_o,
   output logic irq_o
);
   // Software registers.
   logic [4:0] ctrl_reg, ctrl_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [31:0] wdc_reg, wdc_next;
   logic [8:0] wcmd_reg, wcmd_next;
   logic [31:0] key_reg, key_next;
   logic [2:0] istat_reg, istat_next;
   logic [2:0] imask_reg, imask_next;
   logic [31:0] prdata_reg, prdata_next;
   // Write sequencer state.
   camb_wst_t w_state, w_next;
   logic [4:0] wa_reg, wa_next;
   logic wm_reg, wm_next;
   logic wdone_reg, wdone_next;
   // Search sequencer state and result stages.
   camb_sst_t s_state, s_next;
   logic [31:0] skey_reg, skey_next;
   camb_res_t st_reg, st_next;
   camb_res_t res_reg, res_next;
   // Decoded controls and array signals.
   camb_mode_t mode;
   logic unenc, in_reg, out_reg;
   logic apb_wr, apb_setup, mapped;
   logic wr_go, sr_go, wr_take, sr_take;
   logic dat_we, dc_we;
   logic [31:0] wdc_val, kcare, hit, hit_eff, rdata;
   logic [15:0] even_v, odd_v;
   logic [2:0] ev;

   assign mode = camb_mode_t'(ctrl_reg[1:0]);
   assign unenc = ctrl_reg[`CAMB_CTRL_UNENC];
   assign in_reg = ctrl_reg[`CAMB_CTRL_INREG];
   assign out_reg = ctrl_reg[`CAMB_CTRL_OUTREG];
   assign apb_wr = psel_i && penable_i && pwrite_i;
   assign apb_setup = psel_i && !penable_i;

   // Lowest set index wins when several words hit.
   function automatic logic [4:0] camb_prio(input logic [31:0] v);
      logic [4:0] r;
      r = 5'h0;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   // Address decode and read mux, sampled in the setup phase.
   always_comb begin
      mapped = 1'b1;
      prdata_next = prdata_reg;
      if (paddr_i == `CAMB_OFF_CTRL) begin
         prdata_next = {27'h0, ctrl_reg};
      end else if (paddr_i == `CAMB_OFF_WDATA) begin
         prdata_next = wdata_reg;
      end else if (paddr_i == `CAMB_OFF_WDC) begin
         prdata_next = wdc_reg;
      end else if (paddr_i == `CAMB_OFF_WCMD) begin
         prdata_next = {23'h0, wcmd_reg};
      end else if (paddr_i == `CAMB_OFF_KEY) begin
         prdata_next = key_reg;
      end else if (paddr_i == `CAMB_OFF_RES) begin
         prdata_next = {14'h0, s_state != S_IDLE, w_state != W_IDLE,
                        3'h0, res_reg.idx, 7'h0, res_reg.match};
      end else if (paddr_i == `CAMB_OFF_VEC) begin
         prdata_next = res_reg.vec;
      end else if (paddr_i == `CAMB_OFF_ISTAT) begin
         prdata_next = {29'h0, istat_reg};
      end else if (paddr_i == `CAMB_OFF_IMASK) begin
         prdata_next = {29'h0, imask_reg};
      end else begin
         mapped = 1'b0;
         prdata_next = 32'h0;
      end
      if (!apb_setup) begin
         prdata_next = prdata_reg;
      end
   end

   // Register writes; interrupt events beat a same-cycle clear.
   always_comb begin
      ctrl_next = ctrl_reg;
      wdata_next = wdata_reg;
      wdc_next = wdc_reg;
      wcmd_next = wcmd_reg;
      key_next = key_reg;
      imask_next = imask_reg;
      istat_next = istat_reg;
      if (apb_wr) begin
         if (paddr_i == `CAMB_OFF_CTRL) begin
            ctrl_next = pwdata_i[4:0];
         end else if (paddr_i == `CAMB_OFF_WDATA) begin
            wdata_next = pwdata_i;
         end else if (paddr_i == `CAMB_OFF_WDC) begin
            wdc_next = pwdata_i;
         end else if (paddr_i == `CAMB_OFF_WCMD) begin
            wcmd_next = pwdata_i[8:0];
         end else if (paddr_i == `CAMB_OFF_KEY) begin
            key_next = pwdata_i;
         end else if (paddr_i == `CAMB_OFF_ISTAT) begin
            istat_next = istat_reg & ~pwdata_i[2:0];
         end else if (paddr_i == `CAMB_OFF_IMASK) begin
            imask_next = pwdata_i[2:0];
         end
      end
      istat_next = istat_next | ev;
   end

   // Software registers hold their reset values until written, except istat_reg, which events also set, and prdata_reg, loaded each setup phase.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= `CAMB_CTRL_RST;
         wdata_reg <= 32'h0;
         wdc_reg <= 32'h0;
         wcmd_reg <= 9'h0;
         key_reg <= 32'h0;
         istat_reg <= 3'h0;
         imask_reg <= 3'h0;
         prdata_reg <= 32'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         wdata_reg <= wdata_next;
         wdc_reg <= wdc_next;
         wcmd_reg <= wcmd_next;
         key_reg <= key_next;
         istat_reg <= istat_next;
         imask_reg <= imask_next;
         prdata_reg <= prdata_next;
      end
   end

   // Commands come from the bus or from fabric strobes.
   assign wr_go = (apb_wr && paddr_i == `CAMB_OFF_WCMD) || fab_wr_i;
   assign sr_go = (apb_wr && paddr_i == `CAMB_OFF_KEY) || fab_rd_i;
   assign wr_take = w_state == W_IDLE && wr_go && mode != CAMB_LUT
                    && !fab_sclr_i;
   assign sr_take = s_state == S_IDLE && sr_go && !fab_sclr_i;

   // Write sequencer: address, data, then optional mask cycle.
   always_comb begin
      w_next = w_state;
      wa_next = wa_reg;
      wm_next = wm_reg;
      wdone_next = 1'b0;
      dat_we = 1'b0;
      dc_we = 1'b0;
      wdc_val = 32'h0;
      if (fab_sclr_i) begin
         w_next = W_IDLE;
      end else begin
         case (w_state)
            W_IDLE: begin
               // Lookup-table contents are fixed, so writes are ignored.
               if (wr_take) begin
                  wa_next = wcmd_next[4:0];
                  wm_next = wcmd_next[`CAMB_WCMD_MASK];
                  w_next = W_ADDR;
               end
            end
            W_ADDR: begin
               // Inputs are relied on to stay stable meanwhile.
               if (in_ce_i) begin
                  w_next = W_DATA;
               end
            end
            W_DATA: begin
               // Second cycle stores the word; plain writes clear mask.
               if (in_ce_i) begin
                  dat_we = 1'b1;
                  dc_we = !wm_reg;
                  wdone_next = !wm_reg;
                  w_next = wm_reg ? W_MASK : W_IDLE;
               end
            end
            W_MASK: begin
               // Third cycle stores the don't-care bits.
               if (in_ce_i) begin
                  dc_we = 1'b1;
                  wdc_val = wdc_reg;
                  wdone_next = 1'b1;
                  w_next = W_IDLE;
               end
            end
            default: begin
               w_next = W_IDLE;
            end
         endcase
      end
   end

   // Write sequencer registers.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         w_state <= W_IDLE;
         wa_reg <= 5'h0;
         wm_reg <= 1'b0;
         wdone_reg <= 1'b0;
      end else begin
         w_state <= w_next;
         wa_reg <= wa_next;
         wm_reg <= wm_next;
         wdone_reg <= wdone_next;
      end
   end

   // With unencoded output the top key bit is not compared.
   assign kcare = unenc ? `CAMB_CARE31 : `CAMB_ALL_ONES;
   // Fast mode only uses the lower 16 words.
   assign hit_eff = (mode == CAMB_FAST) ? {16'h0, hit[15:0]} : hit;

   // Split the hit vector into even and odd banks.
   for (genvar b = 0; b < `CAMB_BANK; b++) begin : g_bank
      assign even_v[b] = hit_eff[2*b];
      assign odd_v[b] = hit_eff[2*b+1];
   end

   // Search sequencer and first result stage.
   always_comb begin
      s_next = s_state;
      skey_next = skey_reg;
      st_next = st_reg;
      st_next.done = 1'b0;
      if (fab_sclr_i) begin
         s_next = S_IDLE;
         st_next = '0;
      end else begin
         case (s_state)
            S_IDLE: begin
               // Optional input stage costs one extra cycle.
               if (sr_take) begin
                  skey_next = sr_go && fab_rd_i && !apb_wr ?
                              key_reg : key_next;
                  s_next = in_reg ? S_INREG : S_CMP;
               end
            end
            S_INREG: begin
               if (in_ce_i) begin
                  s_next = S_CMP;
               end
            end
            S_CMP: begin
               if (in_ce_i) begin
                  st_next.match = |hit_eff;
                  st_next.idx = camb_prio(hit_eff);
                  st_next.hi = 1'b0;
                  st_next.done = 1'b1;
                  s_next = S_IDLE;
                  if (mode == CAMB_LUT) begin
                     // Table mode returns the word at the key address.
                     st_next.match = 1'b1;
                     st_next.idx = skey_reg[4:0];
                     st_next.vec = rdata;
                  end else if (mode == CAMB_SINGLE) begin
                     // Both encoded index and bank vector are ready.
                     st_next.vec = {16'h0, (unenc && skey_reg[31]) ?
                                    odd_v : even_v};
                  end else if (mode == CAMB_FAST) begin
                     st_next.vec = {16'h0, hit_eff[15:0]};
                  end else begin
                     // Even bank now, odd bank next cycle; no index.
                     st_next.idx = 5'h0;
                     st_next.vec = {16'h0, even_v};
                     st_next.done = 1'b0;
                     s_next = S_CMP2;
                  end
               end
            end
            S_CMP2: begin
               if (in_ce_i) begin
                  st_next.vec[31:16] = odd_v;
                  st_next.hi = 1'b1;
                  st_next.done = 1'b1;
                  s_next = S_IDLE;
               end
            end
            default: begin
               s_next = S_IDLE;
            end
         endcase
      end
   end

   // Output stage follows the first stage, one cycle later if chosen.
   always_comb begin
      res_next = res_reg;
      res_next.done = 1'b0;
      if (fab_sclr_i) begin
         res_next = '0;
      end else if (out_ce_i) begin
         res_next = out_reg ? st_reg : st_next;
      end
   end

   // Search registers.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_state <= S_IDLE;
         skey_reg <= 32'h0;
         st_reg <= '0;
         res_reg <= '0;
      end else begin
         s_state <= s_next;
         skey_reg <= skey_next;
         st_reg <= st_next;
         res_reg <= res_next;
      end
   end

   // Storage array with 32 words of 32 bits.
   camb_array u_array (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .dat_we_i(dat_we),
      .dc_we_i(dc_we),
      .waddr_i(wa_reg),
      .wdata_i(wdata_reg),
      .wdc_i(wdc_val),
      .key_i(skey_reg),
      .kcare_i(kcare),
      .raddr_i(skey_reg[4:0]),
      .rdata_o(rdata),
      .hit_o(hit)
   );

   // Interrupt events and outputs.
   assign ev[`CAMB_INT_WR] = wdone_reg;
   assign ev[`CAMB_INT_SR] = res_reg.done;
   assign ev[`CAMB_INT_HIT] = res_reg.done && res_reg.match;
   assign irq_o = |(istat_reg & imask_reg);
   assign prdata_o = prdata_reg;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;
   assign match_o = res_reg.match;
   assign match_idx_o = res_reg.idx;
   assign match_vec_o = res_reg.hi ? res_reg.vec[31:16] : res_reg.vec[15:0];

   // Plain write: two enabled cycles, then done.
   sequence wr_norm_s;
      wr_take && !wcmd_next[`CAMB_WCMD_MASK] ##1 in_ce_i [*2];
   endsequence
   // Masked write: three enabled cycles, then done.
   sequence wr_mask_s;
      wr_take && wcmd_next[`CAMB_WCMD_MASK] ##1 in_ce_i [*3];
   endsequence
   // Search without extra stages in a one-pass mode.
   sequence sr_one_s;
      sr_take && mode != CAMB_MULTI && !in_reg && !out_reg
      ##1 (in_ce_i && out_ce_i);
   endsequence
   // Search without extra stages in multiple-match mode.
   sequence sr_two_s;
      sr_take && mode == CAMB_MULTI && !in_reg && !out_reg
      ##1 (in_ce_i && out_ce_i) [*2];
   endsequence

   wr_two_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i || fab_sclr_i)
      wr_norm_s |-> !wdone_reg ##1 wdone_reg)
      else $error("plain write not done after two cycles");
   wr_three_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i || fab_sclr_i)
      wr_mask_s |-> !wdone_reg ##1 wdone_reg)
      else $error("masked write not done after three cycles");
   search_one_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i || fab_sclr_i)
      sr_one_s |=> res_reg.done)
      else $error("search result not valid after one cycle");
   multi_two_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i || fab_sclr_i)
      sr_two_s |-> !res_reg.done ##1 (res_reg.done && res_reg.hi))
      else $error("multiple-match search not done in two cycles");
   match_flag_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i || fab_sclr_i)
      (s_state == S_CMP && mode != CAMB_LUT && in_ce_i)
      |=> st_reg.match == |$past(hit_eff))
      else $error("match flag disagrees with compare");
   enc_index_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i || fab_sclr_i)
      (s_state == S_CMP && mode == CAMB_SINGLE && in_ce_i && |hit_eff)
      |=> (($past(hit_eff) >> st_reg.idx) & 32'h1) == 32'h1)
      else $error("encoded index is not a hitting word");
   bank_sel_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i || fab_sclr_i)
      (s_state == S_CMP && mode == CAMB_SINGLE && unenc && in_ce_i)
      |=> st_reg.vec[15:0] == ($past(skey_reg[31]) ?
                               $past(odd_v) : $past(even_v)))
      else $error("bank select picked the wrong words");
   lut_nowr_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i || fab_sclr_i)
      (w_state == W_IDLE && wr_go && mode == CAMB_LUT) |=> w_state == W_IDLE)
      else $error("write accepted in lookup-table mode");
endmodule
`default_nettype wire

/* tb/camb_fabric.sv */
// Fabric-side partner: strobe pulses and the priority encoder.
`default_nettype none
module camb_fabric (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic rd_go_i,
   input wire logic wr_go_i,
   input wire logic [31:0] vec_i,
   output logic fab_rd_o,
   output logic fab_wr_o,
   output logic hit_o,
   output logic [4:0] idx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd_reg, wr_reg; // Last go levels.
   // Remember the go levels so that a rise gives a one-cycle strobe.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
      end else begin
         rd_reg <= rd_go_i;
         wr_reg <= wr_go_i;
      end
   end
   assign fab_rd_o = rd_go_i & ~rd_reg;
   assign fab_wr_o = wr_go_i & ~wr_reg;
   // Lowest matching word wins; even words sit low, odd words high.
   always_comb begin
      hit_o = 1'b0;
      idx_o = 5'h00;
      for (int i = 15; i >= 0; i--) begin
         if (vec_i[16+i]) begin
            hit_o = 1'b1;
            idx_o = 5'(2 * i + 1);
         end
         if (vec_i[i]) begin
            hit_o = 1'b1;
            idx_o = 5'(2 * i);
         end
      end
   end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the search memory block.
`default_nettype none
`include "camb_defs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic in_ce = 1'b1, out_ce = 1'b1, sclr = 1'b0, stall = 1'b0;
   logic rd_go = 1'b0, wr_go = 1'b0, err, pready, pslverr, mt, irq;
   logic fwr, frd, phit;
   logic [4:0] midx, pidx;
   logic [7:0] paddr = 8'h00;
   logic [15:0] mvec;
   logic [31:0] pwdata = 32'h0, prdata, r, d, vecw = 32'h0;
   logic [31:0] exp_q[$], obs_q[$]; // Notes of expected and seen values.
   int seed = 86232, failures = 0, cmp_count = 0;
   always #12.5 clk = ~clk;
   camb_top i_camb_top(.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .in_ce_i(in_ce), .out_ce_i(out_ce), .fab_wr_i(fwr), .fab_rd_i(frd),
      .fab_sclr_i(sclr), .match_o(mt), .match_idx_o(midx),
      .match_vec_o(mvec), .irq_o(irq));
   camb_fabric i_camb_fabric(.clk_i(clk), .rst_n_i(rst_n), .rd_go_i(rd_go),
      .wr_go_i(wr_go), .vec_i(vecw), .fab_rd_o(frd), .fab_wr_o(fwr),
      .hit_o(phit), .idx_o(pidx));
   // Random input-side stalls while stall is set.
   always @(posedge clk) in_ce <= !stall || (($random(seed) & 1) != 0);
   // Monitor: pair each seen value with the oldest expectation.
   always @(posedge clk) begin
      while (obs_q.size() > 0) begin
         cmp_count++;
         if (obs_q[0] !== exp_q[0]) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, obs_q[0], exp_q[0]);
         end
         obs_q.delete(0);
         exp_q.delete(0);
      end
   end
   task close_out();
      if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      obs_q.push_back(g);
      exp_q.push_back(e);
   endtask
   // One APB transfer; the request holds until pready is seen high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   // Poll a sticky status bit, then clear all status bits.
   task wait_ist(input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, `CAMB_OFF_ISTAT, 32'h0);
         n++;
      end while (r[b] !== 1'b1 && n < 40);
      chk(32'(r[b]), 32'h1);
      apb(1'b1, `CAMB_OFF_ISTAT, 32'h7);
   endtask
   task mode(input logic [4:0] c);
      apb(1'b1, `CAMB_OFF_CTRL, {27'h0, c});
   endtask
   task srch(input logic [31:0] k);
      apb(1'b1, `CAMB_OFF_KEY, k);
      wait_ist(1);
      apb(1'b0, `CAMB_OFF_RES, 32'h0);
   endtask
   // Result both in the status word and at the ports.
   task res(input logic [4:0] i, input logic m);
      chk(32'({r[12:8], r[0]}), 32'({i, m}));
      chk(32'({midx, mt}), 32'({i, m}));
   endtask
   task wrw(input logic [4:0] a, input logic [31:0] v, dc, input logic m);
      apb(1'b1, `CAMB_OFF_WDATA, v);
      apb(1'b1, `CAMB_OFF_WDC, dc);
      apb(1'b1, `CAMB_OFF_WCMD, {23'h0, m, 3'h0, a});
      wait_ist(0);
   endtask
   // Watchdog well beyond the few hundred cycles the run needs.
   initial begin
      #(25.0 * 20000);
      failures++;
      close_out();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      mode(5'h00);
      srch(32'h5);
      res(5'd5, 1'b1);
      srch(32'h40);
      res(5'd0, 1'b0);
      apb(1'b0, 8'h24, 32'h0);
      chk(32'(err), 32'h1);
      d = $random(seed) | 32'h00000100; // Never equals a preset word.
      stall <= 1'b1;
      wrw(5'd7, d, 32'h0, 1'b0);
      srch(d);
      res(5'd7, 1'b1);
      stall <= 1'b0;
      wrw(5'd4, 32'h0000a500, 32'h000000ff, 1'b1);
      srch(32'h0000a53c);
      res(5'd4, 1'b1);
      wrw(5'd3, 32'h9, 32'h0, 1'b0);
      wr_go <= 1'b1;
      @(posedge clk);
      wr_go <= 1'b0;
      wait_ist(0);
      srch(32'h9);
      res(5'd3, 1'b1);
      rd_go <= 1'b1;
      @(posedge clk);
      rd_go <= 1'b0;
      wait_ist(1);
      sclr <= 1'b1;
      @(posedge clk);
      sclr <= 1'b0;
      @(posedge clk);
      chk(32'(mt), 32'h0);
      mode(5'h01);
      srch(32'h9);
      apb(1'b0, `CAMB_OFF_VEC, 32'h0);
      chk(r, 32'h00120000);
      vecw <= r;
      @(posedge clk);
      chk(32'({phit, pidx}), 32'({1'b1, 5'd3}));
      mode(5'h02);
      srch(32'h9);
      chk(32'(mvec), 32'h0208);
      srch(32'd20);
      chk(32'(mt), 32'h0);
      mode(5'h04);
      srch({1'b1, 31'h5});
      chk(32'(mvec), 32'h0004);
      srch({1'b0, 31'h6});
      chk(32'(mvec), 32'h0008);
      mode(5'h18);
      srch(32'h6);
      res(5'd6, 1'b1);
      // Output side frozen: a new search must not reach the ports.
      out_ce <= 1'b0;
      apb(1'b1, `CAMB_OFF_KEY, 32'h40);
      repeat (6) @(posedge clk);
      chk(32'(mt), 32'h1);
      out_ce <= 1'b1;
      // A fully masked word hits whatever the key is.
      wrw(5'd31, 32'h0, `CAMB_ALL_ONES, 1'b1);
      srch(32'h40);
      res(5'd31, 1'b1);
      mode(5'h03);
      // Table contents are fixed, so this word write must be ignored.
      apb(1'b1, `CAMB_OFF_WDATA, 32'h77);
      apb(1'b1, `CAMB_OFF_WCMD, 32'h3);
      srch(32'h3);
      apb(1'b0, `CAMB_OFF_VEC, 32'h0);
      chk(r, 32'h9);
      mode(5'h00);
      apb(1'b1, `CAMB_OFF_KEY, 32'h5);
      repeat (8) @(posedge clk);
      chk(32'(irq), 32'h0);
      apb(1'b1, `CAMB_OFF_IMASK, 32'h2);
      chk(32'(irq), 32'h1);
      apb(1'b1, `CAMB_OFF_ISTAT, 32'h7);
      chk(32'(irq), 32'h0);
      repeat (2) @(posedge clk);
      close_out();
   end
endmodule
`default_nettype wire
